// ### hdl/bst_pkg.sv
package bst_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int BST_IR_LEN = 3;
    localparam int BST_BSR_LEN = 38;
    localparam int BST_ID_LEN = 32;
    localparam int BST_TM_LEN = 8;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [2:0] BST_OP_EXTEST = 3'h0;
    localparam logic [2:0] BST_OP_SAMPLE = 3'h1;
    localparam logic [2:0] BST_OP_IDCODE = 3'h2;
    localparam logic [2:0] BST_OP_TESTMODE = 3'h3;
    localparam logic [2:0] BST_OP_HIGHZ = 3'h4;
    localparam logic [2:0] BST_OP_CLAMP = 3'h6;
    localparam logic [2:0] BST_IR_CAPTURE = 3'h5;

    // ------------------------------------------------------------
    // Identification fields
    // ------------------------------------------------------------
    localparam int BST_ID_VER_LSB = 28;
    localparam int BST_ID_PART_LSB = 12;
    localparam int BST_ID_MFR_LSB = 1;
    localparam logic [3:0] BST_ID_VERSION = 4'h1;
    // Arbitrary neutral values
    localparam logic [15:0] BST_ID_PART = 16'h0a5a;
    localparam logic [10:0] BST_ID_MFR = 11'h055;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BST_TM_RESET = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int BST_CLK_PERIOD_NS = 4;
    localparam int BST_TCK_MIN_PERIOD_NS = 100;
    localparam int BST_TCK_PERIOD_CYCLES = BST_TCK_MIN_PERIOD_NS / BST_CLK_PERIOD_NS;
    localparam int BST_SYNC_LATENCY = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        BST_TLR = 16'h0001,
        BST_RTI = 16'h0002,
        BST_SEL_DR = 16'h0004,
        BST_CAP_DR = 16'h0008,
        BST_SHIFT_DR = 16'h0010,
        BST_EXIT1_DR = 16'h0020,
        BST_PAUSE_DR = 16'h0040,
        BST_EXIT2_DR = 16'h0080,
        BST_UPD_DR = 16'h0100,
        BST_SEL_IR = 16'h0200,
        BST_CAP_IR = 16'h0400,
        BST_SHIFT_IR = 16'h0800,
        BST_EXIT1_IR = 16'h1000,
        BST_PAUSE_IR = 16'h2000,
        BST_EXIT2_IR = 16'h4000,
        BST_UPD_IR = 16'h8000
    } bst_state_type;

    typedef enum logic [1:0] {
        BST_DR_BSR = 2'h0,
        BST_DR_ID = 2'h1,
        BST_DR_TM = 2'h2,
        BST_DR_BYP = 2'h3
    } bst_dr_type;

endpackage : bst_pkg

// ### hdl/bst_tap.sv
`timescale 1ns/1ns
module bst_tap
    import bst_pkg::*;
#(
    parameter int BSR_LEN = BST_BSR_LEN
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic half_rate_line_clock_in,
    input wire logic [BSR_LEN-1:0] bsr_pin_in,
    input wire logic [BSR_LEN-1:0] core_pin_value,
    output logic tdo_pin,
    output logic tdo_pin_oe,
    output logic [BSR_LEN-1:0] pin_value,
    output logic pin_force_z,
    output logic [BSR_LEN-1:0] bsr_update,
    output logic [7:0] vendor_test_mode_register
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (BSR_LEN != BST_BSR_LEN || BST_TCK_PERIOD_CYCLES < 2 * BST_SYNC_LATENCY) begin : g_bad_params
        $error("bst_tap: unsupported parameters");
    end

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic bst_dr_type bst_dr_select(input logic [2:0] op);
        bst_dr_type sel;
        sel = BST_DR_BYP;
        if (op[2]) begin
            sel = BST_DR_BYP;
        end else if (op == BST_OP_EXTEST || op == BST_OP_SAMPLE) begin
            sel = BST_DR_BSR;
        end else if (op == BST_OP_IDCODE) begin
            sel = BST_DR_ID;
        end else begin
            sel = BST_DR_TM;
        end
        return sel;
    endfunction : bst_dr_select

    function automatic bst_state_type bst_next(input bst_state_type s, input logic m);
        bst_state_type n;
        n = BST_TLR;
        unique case (s)
            BST_TLR: n = m ? BST_TLR : BST_RTI;
            BST_RTI: n = m ? BST_SEL_DR : BST_RTI;
            BST_SEL_DR: n = m ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR: n = m ? BST_EXIT1_DR : BST_SHIFT_DR;
            BST_SHIFT_DR: n = m ? BST_EXIT1_DR : BST_SHIFT_DR;
            BST_EXIT1_DR: n = m ? BST_UPD_DR : BST_PAUSE_DR;
            BST_PAUSE_DR: n = m ? BST_EXIT2_DR : BST_PAUSE_DR;
            BST_EXIT2_DR: n = m ? BST_UPD_DR : BST_SHIFT_DR;
            BST_UPD_DR: n = m ? BST_SEL_DR : BST_RTI;
            BST_SEL_IR: n = m ? BST_TLR : BST_CAP_IR;
            BST_CAP_IR: n = m ? BST_EXIT1_IR : BST_SHIFT_IR;
            BST_SHIFT_IR: n = m ? BST_EXIT1_IR : BST_SHIFT_IR;
            BST_EXIT1_IR: n = m ? BST_UPD_IR : BST_PAUSE_IR;
            BST_PAUSE_IR: n = m ? BST_EXIT2_IR : BST_PAUSE_IR;
            BST_EXIT2_IR: n = m ? BST_UPD_IR : BST_SHIFT_IR;
            BST_UPD_IR: n = m ? BST_SEL_DR : BST_RTI;
            default: n = BST_TLR;
        endcase
        return n;
    endfunction : bst_next

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic tck_m, tck_s, tck_d;
    logic tms_m, tms_s;
    logic tdi_m, tdi_s;
    logic [BSR_LEN-1:0] bsr_in_m, bsr_in_s;
    logic tck_rise, tck_fall;

    always_ff @(posedge clk) begin
        if (rst) begin
            tck_m <= 1'b0;
            tck_s <= 1'b0;
            tck_d <= 1'b0;
            tms_m <= 1'b1;
            tms_s <= 1'b1;
            tdi_m <= 1'b0;
            tdi_s <= 1'b0;
            bsr_in_m <= '0;
            bsr_in_s <= '0;
        end else begin
            tck_m <= tck;
            tck_s <= tck_m;
            tck_d <= tck_s;
            tms_m <= tms;
            tms_s <= tms_m;
            tdi_m <= tdi;
            tdi_s <= tdi_m;
            bsr_in_m <= bsr_pin_in;
            bsr_in_s <= bsr_in_m;
        end
    end

    // Edges seen only on the second-stage copy; a stopped clock leaves no edge
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    // ------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------
    bst_state_type state;

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= BST_TLR;
        end else if (tck_rise) begin
            state <= bst_next(state, tms_s);
        end
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    logic [BST_IR_LEN-1:0] ir_shift;
    logic [BST_IR_LEN-1:0] ir_active;
    bst_dr_type dr_sel;

    always_ff @(posedge clk) begin
        if (rst) begin
            ir_shift <= BST_IR_CAPTURE;
        end else if (tck_rise && state == BST_CAP_IR) begin
            ir_shift <= BST_IR_CAPTURE;
        end else if (tck_rise && state == BST_SHIFT_IR) begin
            ir_shift <= {tdi_s, ir_shift[BST_IR_LEN-1:1]};
        end
    end

    // Only six instruction codes are named; no self-test code is decoded
    always_ff @(posedge clk) begin
        if (rst || state == BST_TLR) begin
            ir_active <= BST_OP_IDCODE;
        end else if (tck_rise && state == BST_UPD_IR) begin
            ir_active <= ir_shift;
        end
    end

    assign dr_sel = bst_dr_select(ir_active);

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    logic [BSR_LEN-1:0] bsr_shift;
    logic [BST_ID_LEN-1:0] id_shift;
    logic [BST_TM_LEN-1:0] tm_shift;
    logic byp;
    logic [BST_ID_LEN-1:0] id_value;

    assign id_value = {BST_ID_VERSION, BST_ID_PART, BST_ID_MFR, 1'b1};

    always_ff @(posedge clk) begin
        if (rst) begin
            bsr_shift <= '0;
        end else if (tck_rise && dr_sel == BST_DR_BSR && state == BST_CAP_DR) begin
            bsr_shift <= bsr_in_s;
        end else if (tck_rise && dr_sel == BST_DR_BSR && state == BST_SHIFT_DR) begin
            bsr_shift <= {tdi_s, bsr_shift[BSR_LEN-1:1]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            id_shift <= '0;
        end else if (tck_rise && dr_sel == BST_DR_ID && state == BST_CAP_DR) begin
            id_shift <= id_value;
        end else if (tck_rise && dr_sel == BST_DR_ID && state == BST_SHIFT_DR) begin
            id_shift <= {tdi_s, id_shift[BST_ID_LEN-1:1]};
        end
    end

    // No capture: the last word shifted in comes back out for checking
    always_ff @(posedge clk) begin
        if (rst) begin
            tm_shift <= BST_TM_RESET;
        end else if (tck_rise && dr_sel == BST_DR_TM && state == BST_SHIFT_DR) begin
            tm_shift <= {tdi_s, tm_shift[BST_TM_LEN-1:1]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            byp <= 1'b0;
        end else if (tck_rise && dr_sel == BST_DR_BYP && state == BST_CAP_DR) begin
            byp <= 1'b0;
        end else if (tck_rise && dr_sel == BST_DR_BYP && state == BST_SHIFT_DR) begin
            byp <= tdi_s;
        end
    end

    // ------------------------------------------------------------
    // Update stages
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            bsr_update <= '0;
        end else if (tck_rise && dr_sel == BST_DR_BSR && state == BST_UPD_DR) begin
            bsr_update <= bsr_shift;
        end
    end

    // Loading this from a tester may leave the chip in an undefined mode
    always_ff @(posedge clk) begin
        if (rst) begin
            vendor_test_mode_register <= BST_TM_RESET;
        end else if (tck_rise && dr_sel == BST_DR_TM && state == BST_UPD_DR) begin
            vendor_test_mode_register <= tm_shift;
        end
    end

    // ------------------------------------------------------------
    // Output pin control
    // ------------------------------------------------------------
    logic drive_scan;
    assign drive_scan = ir_active == BST_OP_EXTEST || ir_active == BST_OP_CLAMP;

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_value <= '0;
            pin_force_z <= 1'b0;
        end else begin
            pin_value <= drive_scan ? bsr_update : core_pin_value;
            pin_force_z <= ir_active == BST_OP_HIGHZ;
        end
    end

    // ------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------
    logic tdo;
    logic tdo_drive;
    logic dr_lsb;

    always_comb begin
        unique case (dr_sel)
            BST_DR_BSR: dr_lsb = bsr_shift[0];
            BST_DR_ID: dr_lsb = id_shift[0];
            BST_DR_TM: dr_lsb = tm_shift[0];
            BST_DR_BYP: dr_lsb = byp;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tdo <= 1'b0;
            tdo_drive <= 1'b0;
        end else if (tck_fall) begin
            tdo <= state == BST_SHIFT_IR ? ir_shift[0] : dr_lsb;
            tdo_drive <= state == BST_SHIFT_IR || state == BST_SHIFT_DR;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tdo_pin <= 1'b0;
            tdo_pin_oe <= 1'b1;
        end else if (state == BST_TLR) begin
            tdo_pin <= half_rate_line_clock_in;
            tdo_pin_oe <= 1'b1;
        end else begin
            tdo_pin <= tdo;
            tdo_pin_oe <= tdo_drive;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_cap_ir;
        tck_rise && state == BST_CAP_IR;
    endsequence

    sequence s_cap_tm;
        tck_rise && state == BST_CAP_DR && dr_sel == BST_DR_TM;
    endsequence

    AST_IR_CAPTURE: assert property (@(posedge clk) disable iff (rst)
        s_cap_ir |=> ir_shift == 3'h5)
        else $error("capture-ir pattern wrong");

    AST_RESET_TLR: assert property (@(posedge clk)
        rst |=> state == BST_TLR)
        else $error("reset did not force test-logic-reset");

    AST_TLR_IDCODE: assert property (@(posedge clk) disable iff (rst)
        state == BST_TLR |=> dr_sel == BST_DR_ID)
        else $error("identification not default path");

    AST_STATE_HOLD: assert property (@(posedge clk) disable iff (rst)
        !tck_rise |=> $stable(state))
        else $error("state moved without rising test clock");

    AST_UPPER_BYPASS: assert property (@(posedge clk) disable iff (rst)
        ir_active[2] |-> dr_sel == BST_DR_BYP)
        else $error("upper codes not on bypass");

    AST_TM_NO_CAPTURE: assert property (@(posedge clk) disable iff (rst)
        s_cap_tm |=> $stable(tm_shift))
        else $error("test-mode register captured");

    AST_TLR_PIN: assert property (@(posedge clk) disable iff (rst)
        state == BST_TLR ##1 state == BST_TLR |-> tdo_pin == $past(half_rate_line_clock_in)
        && tdo_pin_oe)
        else $error("shared pin not carrying line clock");

    AST_HIGHZ: assert property (@(posedge clk) disable iff (rst)
        ir_active == BST_OP_HIGHZ |=> pin_force_z)
        else $error("highz did not tristate pins");

    AST_EXTEST_DRIVE: assert property (@(posedge clk) disable iff (rst)
        ir_active == BST_OP_EXTEST |=> pin_value == $past(bsr_update))
        else $error("extest not driving update stage");

    AST_OE_SHIFT: assert property (@(posedge clk) disable iff (rst)
        tck_fall && state == BST_RTI ##1 state != BST_TLR |-> !tdo_pin_oe [*1] ##1 !tdo_pin_oe)
        else $error("tdo driven outside shift");

    AST_ID_FIELDS: assert property (@(posedge clk) disable iff (rst)
        tck_rise && state == BST_CAP_DR && dr_sel == BST_DR_ID |=> id_shift[0] == 1'b1
        && id_shift[31:28] == 4'h1)
        else $error("identification fields wrong");

endmodule : bst_tap

// ### testbench/bst_tester.sv
`timescale 1ns/1ns
module bst_tester (
    input wire logic clk,
    input wire logic tdo_pin,
    input wire logic tdo_pin_oe,
    output logic tck,
    output logic tms,
    output logic tdi
);
    // ------------------------------------------------------------
    // Test clock pacing
    // ------------------------------------------------------------
    // Half period of 13 clk keeps the test clock under 10 MHz
    localparam int HALF = 13;
    int stall = 0;
    logic oe_ok;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // ------------------------------------------------------------
    // One test clock period; stops low between periods
    // ------------------------------------------------------------
    task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
        wait_clk(1);
        // Mode select glitch while the test clock is steady
        tms = ~tms_v;
        wait_clk(4);
        tms = tms_v;
        tdi = tdi_v;
        // Optional long stop with the clock low
        if (stall > 0) wait_clk(stall);
        wait_clk(HALF - 4);
        // Undriven shared pin reads as the inverse of its last value
        tdo_v = tdo_pin_oe ? tdo_pin : ~tdo_pin;
        tck = 1'b1;
        wait_clk(HALF);
        // Optional long stop with the clock high
        if (stall > 0) wait_clk(stall);
        tck = 1'b0;
    endtask : step

    task automatic to_tlr();
        logic t;
        repeat (5) step(1'b1, tdi, t);
    endtask : to_tlr

    // ------------------------------------------------------------
    // Full scan from Run-Test/Idle back to Run-Test/Idle
    // ------------------------------------------------------------
    // The vendor register is only loaded when the bench asks for it
    task automatic scan(input logic is_ir, input int n, input logic [63:0] din,
            output logic [63:0] dout);
        logic t;
        dout = '0;
        oe_ok = 1'b1;
        step(1'b1, tdi, t);
        if (is_ir) step(1'b1, tdi, t);
        step(1'b0, tdi, t);
        step(1'b0, tdi, t);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
            // Enable here follows the fall that came before this bit's rise
            oe_ok = oe_ok & tdo_pin_oe;
        end
        step(1'b1, tdi, t);
        step(1'b0, tdi, t);
        // Released data line does not keep its last value
        tdi = ~tdi;
    endtask : scan
endmodule : bst_tester

// ### testbench/boundary_scan_tap_tb.sv
`timescale 1ns/1ns
module boundary_scan_tap_tb;
    import bst_pkg::*;

    logic clk, rst, tck, tms, tdi, line_clk, tdo_pin, tdo_pin_oe, pin_force_z;
    logic [37:0] pins, core, pin_value, bsr_update, last_b;
    logic [7:0] vendor_test_mode_register;
    logic [63:0] d;
    int failures = 0;
    int n_checks = 0;
    localparam logic [31:0] ID_EXP = {BST_ID_VERSION, BST_ID_PART, BST_ID_MFR, 1'b1};

    bst_tap #(.BSR_LEN(BST_BSR_LEN)) dut_u (
        .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .half_rate_line_clock_in(line_clk), .bsr_pin_in(pins), .core_pin_value(core),
        .tdo_pin(tdo_pin), .tdo_pin_oe(tdo_pin_oe), .pin_value(pin_value),
        .pin_force_z(pin_force_z), .bsr_update(bsr_update),
        .vendor_test_mode_register(vendor_test_mode_register)
    );

    bst_tester tester_u (
        .clk(clk), .tdo_pin(tdo_pin), .tdo_pin_oe(tdo_pin_oe),
        .tck(tck), .tms(tms), .tdi(tdi)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t mismatch seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic load_ir(input logic [2:0] op);
        logic [63:0] q;
        tester_u.scan(1'b1, 3, {61'h0, op}, q);
        check(q[2:0], 3'h5);
    endtask : load_ir

    task automatic dr(input int n, input logic [63:0] din);
        tester_u.scan(1'b0, n, din, d);
        check(tester_u.oe_ok, 1'b1);
    endtask : dr

    task automatic line_thru();
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            #1 line_clk = v[0];
            @(posedge clk);
            #1;
            check(tdo_pin, v[0]);
        end
        check(tdo_pin_oe, 1'b1);
    endtask : line_thru

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_after_reset();
        logic t;
        line_thru();
        check(vendor_test_mode_register, 8'h00);
        check(pin_force_z, 1'b0);
        check(pin_value, core);
        tester_u.step(1'b0, 1'b0, t);
        tester_u.wait_clk(4);
        check(tdo_pin_oe, 1'b0);
        dr(32, 64'h0);
        check(d[31:0], ID_EXP);
        check(d[31:28], 4'h1);
        check(d[0], 1'b1);
    endtask : t_after_reset

    task automatic t_bsr();
        logic [37:0] b;
        for (int k = 0; k < 2; k++) begin
            b = (k == 0) ? 38'h33_0f0f_5aa5 : 38'h0c_f0f0_a55a;
            pins = 38'h15_a3c5_61fe ^ {38{k[0]}};
            load_ir(k[2:0]);
            dr(46, {18'h0, b, 8'hc3});
            check(d[37:0], pins);
            check(d[45:38], 8'hc3);
            check(bsr_update, b);
            check(pin_value, (k == 0) ? b : core);
            last_b = b;
        end
    endtask : t_bsr

    task automatic t_bypass();
        for (int op = 4; op < 8; op++) begin
            load_ir(op[2:0]);
            dr(8, 64'h96);
            check(d[7:0], 8'h2c);
            check(pin_force_z, op == 4);
            check(pin_value, (op == 6) ? last_b : core);
        end
    endtask : t_bypass

    task automatic t_testmode();
        load_ir(3'h3);
        dr(8, 64'h5a);
        check(vendor_test_mode_register, 8'h5a);
        dr(16, 64'h3c81);
        check(d[7:0], 8'h5a);
        check(d[15:8], 8'h81);
        check(vendor_test_mode_register, 8'h3c);
    endtask : t_testmode

    task automatic t_tlr_return();
        logic t;
        tester_u.to_tlr();
        line_thru();
        tester_u.step(1'b0, 1'b0, t);
        tester_u.stall = 60;
        dr(32, 64'h0);
        tester_u.stall = 0;
        check(d[31:0], ID_EXP);
    endtask : t_tlr_return

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        line_clk = 1'b0;
        pins = 38'h0;
        core = 38'h2a_5c3a_9e01;
        last_b = 38'h0;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        t_after_reset();
        t_bsr();
        t_bypass();
        t_testmode();
        t_tlr_return();
        give_verdict();
    end

    initial begin
        repeat (95000) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule : boundary_scan_tap_tb
